// >>> hw/mcp_pkg.sv
/*
 * Shared constants and types for the card pin mode controller.
 * Assumes byte addresses on an 8-bit register port, 32-bit data.
 */
package mcp_pkg;

    // Register port
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] A_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] A_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] A_TXD = 8'h0C;
    localparam logic [ADDR_W-1:0] A_RCA = 8'h10;
    localparam logic [ADDR_W-1:0] A_DSR = 8'h14;
    // Information window: bit 7 set, word index in bits 6:2
    localparam int INFO_SEL_BIT = 7;
    localparam int INFO_IDX_W = 5;

    // Command register bit positions (bits 0-3 act when written one, bits 4-5 carry values)
    localparam int CB_WIDTH = 0;
    localparam int CB_PULLUP = 1;
    localparam int CB_RESET = 2;
    localparam int CB_APPROVE = 3;
    localparam int CB_WIDE = 4;
    localparam int CB_CONNECT = 5;

    // Information window layout, in 32-bit words
    localparam int IDENT_BITS = 128;
    localparam int CSD_BITS = 128;
    localparam int CONF_BITS = 64;
    localparam int OPCOND_BITS = 32;
    localparam int CSTAT_BITS = 32;
    localparam int EXT_BITS = 512;
    localparam int IW_IDENT = 0;
    localparam int IW_CSD = IW_IDENT + IDENT_BITS / 32;
    localparam int IW_CONF = IW_CSD + CSD_BITS / 32;
    localparam int IW_OPCOND = IW_CONF + CONF_BITS / 32;
    localparam int IW_CSTAT = IW_OPCOND + OPCOND_BITS / 32;
    localparam int IW_EXT = IW_CSTAT + CSTAT_BITS / 32;
    localparam int INFO_MANDATORY = IW_EXT + EXT_BITS / 32;
    localparam int INFO_MAX = 32;

    // Widths and values after reset
    localparam int RCA_W = 16;
    localparam int DSR_W = 16;
    localparam int PULLUP_KOHM = 50;
    localparam logic PULLUP_RST = 1'b1;
    localparam logic [RCA_W-1:0] RCA_RST = 16'h0000;
    localparam logic [DSR_W-1:0] DSR_RST = 16'h0000;

    // Contact bundle; dat[3] is the detect/data bit 3 line
    typedef struct packed {
        logic cmd;
        logic [3:0] dat;
    } mcp_pins_s;

    typedef struct packed {
        logic cmd_drive;
        logic rdwait_req;
        logic irq_req;
        logic xfer_en;
        logic half_duplex;
        logic diff_mode;
        logic io_mode;
    } mcp_ctrl_s;

    localparam int CTRL_W = $bits(mcp_ctrl_s);
    localparam mcp_ctrl_s CTRL_RST = '0;

    typedef enum logic [1:0] {
        MODE_NATIVE,
        MODE_SPI,
        MODE_DIFF
    } mcp_mode_e;

endpackage

// >>> hw/mcp_pin_mode.sv
/*
 * Card-side pin mode controller: picks native, serial peripheral or
 * differential pin use, owns the detect pull-up, relative address,
 * driver stage and the information words.
 * Assumes a card core on clk_sys behind the register port; the card
 * clock and all contacts arrive asynchronously.
 */
// Implementation choices: the address map and the plain strobed port.
`timescale 1ns/1ns
module mcp_pin_mode #(
    parameter int INFO_WORDS = mcp_pkg::INFO_MANDATORY,
    parameter bit HAS_DSR = 1'b1
) (
    // Clock and power-on reset
    input wire logic clk_sys,
    input wire logic rst,
    // Register port
    input wire logic [mcp_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Card contacts
    input wire logic card_clk_pin,
    input wire mcp_pkg::mcp_pins_s pin_in,
    output mcp_pkg::mcp_pins_s pin_out,
    output mcp_pkg::mcp_pins_s pin_oe,
    output logic detect_pullup_en,
    // Mode view for the card core
    output logic spi_mode,
    output logic serial_in,
    output logic refclk_on_data,
    output logic lane_zero_drive,
    output logic lane_one_drive,
    output logic [mcp_pkg::RCA_W-1:0] local_addr,
    output logic local_addr_valid,
    output logic [mcp_pkg::DSR_W-1:0] driver_stage
);
    import mcp_pkg::*;

    if (INFO_WORDS < INFO_MANDATORY || INFO_WORDS > INFO_MAX) begin : g_chk
        $error("INFO_WORDS out of range");
    end

    // Two-flop synchroniser for the card clock and every contact
    logic [5:0] sync1_r;
    logic [5:0] sync2_r;
    logic clk_last_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            clk_last_r <= 1'b0;
        end else begin
            sync1_r <= {card_clk_pin, pin_in};
            sync2_r <= sync1_r;
            clk_last_r <= sync2_r[5];
        end
    end

    wire logic clk_s = sync2_r[5];
    wire mcp_pins_s pins_s = mcp_pins_s'(sync2_r[4:0]);
    wire logic clk_fall = clk_last_r & ~clk_s;
    wire logic cs_low = ~pins_s.dat[3];

    // Address decode
    wire logic sel_ctrl = reg_addr == A_CTRL;
    wire logic sel_cmd = reg_addr == A_CMD;
    wire logic sel_stat = reg_addr == A_STAT;
    wire logic sel_txd = reg_addr == A_TXD;
    wire logic sel_rca = reg_addr == A_RCA;
    wire logic sel_dsr = reg_addr == A_DSR;
    wire logic sel_info = reg_addr[INFO_SEL_BIT];
    wire logic [INFO_IDX_W-1:0] info_idx = reg_addr[INFO_IDX_W+1:2];
    wire logic info_ok = 32'(info_idx) < INFO_WORDS;

    wire logic cmd_hit = reg_wr & sel_cmd;
    wire logic width_cmd = cmd_hit & reg_wdata[CB_WIDTH];
    wire logic pullup_cmd = cmd_hit & reg_wdata[CB_PULLUP];
    wire logic reset_cmd = cmd_hit & reg_wdata[CB_RESET];
    wire logic approve_cmd = cmd_hit & reg_wdata[CB_APPROVE];

    // Software-steered control and transmit bits
    mcp_ctrl_s ctrl_r;
    mcp_pins_s txd_r;
    mcp_pins_s txq_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            txd_r <= '1;
            txq_r <= '1;
        end else begin
            if (reg_wr && sel_ctrl) begin
                ctrl_r <= mcp_ctrl_s'(reg_wdata[CTRL_W-1:0]);
            end
            if (reg_wr && sel_txd) begin
                txd_r <= mcp_pins_s'(reg_wdata[4:0]);
            end
            // Outputs change on the card clock's falling edge so the
            // host sees them settled at its rising edge
            if (clk_fall) begin
                txq_r <= txd_r;
            end
        end
    end

    // Mode, width, pull-up and address state
    logic spi_r;
    logic wide_r;
    logic pullup_r;
    logic rca_ok_r;
    logic [RCA_W-1:0] rca_r;
    logic [DSR_W-1:0] dsr_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_r <= 1'b0;
            wide_r <= 1'b0;
            pullup_r <= PULLUP_RST;
            rca_ok_r <= 1'b0;
            rca_r <= RCA_RST;
        end else begin
            if (reset_cmd) begin
                spi_r <= cs_low;
                wide_r <= 1'b0;
                rca_ok_r <= 1'b0;
                rca_r <= RCA_RST;
            end else begin
                if (width_cmd && !spi_r) begin
                    wide_r <= reg_wdata[CB_WIDE];
                end
                if (approve_cmd && !spi_r) begin
                    rca_ok_r <= 1'b1;
                end
                // Proposal is frozen once the host has approved it
                if (reg_wr && sel_rca && !spi_r && !rca_ok_r) begin
                    rca_r <= reg_wdata[RCA_W-1:0];
                end
            end
            if (pullup_cmd) begin
                pullup_r <= reg_wdata[CB_CONNECT];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dsr_r <= DSR_RST;
        end else if (reg_wr && sel_dsr && HAS_DSR) begin
            dsr_r <= reg_wdata[DSR_W-1:0];
        end
    end

    // Information words, loaded by the card core
    logic [31:0] info_mem [INFO_WORDS];
    always_ff @(posedge clk_sys) begin
        if (reg_wr && sel_info && info_ok) begin
            info_mem[info_idx] <= reg_wdata;
        end
    end

    // Pin direction and level per mode
    mcp_mode_e mode;
    assign mode = ctrl_r.diff_mode ? MODE_DIFF :
        (spi_r ? MODE_SPI : MODE_NATIVE);
    wire logic io_irq = ctrl_r.io_mode & ctrl_r.irq_req;
    wire logic busy_wide = ctrl_r.xfer_en & wide_r;

    mcp_pins_s oe_nxt;
    mcp_pins_s out_nxt;
    always_comb begin
        oe_nxt = '0;
        out_nxt = txq_r;
        unique case (mode)
            MODE_DIFF: begin
                // Lines 0/1 carry the reference clock, line 2 shows the interrupt, rest left alone
                if (io_irq) begin
                    oe_nxt.dat[2] = 1'b1;
                    out_nxt.dat[2] = 1'b0;
                end
            end
            MODE_SPI: begin
                if (cs_low) begin
                    oe_nxt.dat[0] = 1'b1;
                end
            end
            MODE_NATIVE: begin
                if (ctrl_r.xfer_en) begin
                    oe_nxt.dat[0] = 1'b1;
                    oe_nxt.dat[3:1] = {3{wide_r}};
                end
                oe_nxt.cmd = ctrl_r.cmd_drive;
                if (io_irq && !busy_wide) begin
                    oe_nxt.dat[1] = 1'b1;
                    out_nxt.dat[1] = 1'b0;
                end
                if (ctrl_r.io_mode && ctrl_r.rdwait_req && wide_r) begin
                    oe_nxt.dat[2] = 1'b1;
                    out_nxt.dat[2] = 1'b0;
                end
            end
            default: begin
                oe_nxt = '0;
            end
        endcase
    end

    mcp_pins_s pin_oe_r;
    mcp_pins_s pin_out_r;
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            pin_oe_r <= '0;
            pin_out_r <= '1;
        end else begin
            pin_oe_r <= oe_nxt;
            pin_out_r <= out_nxt;
        end
    end

    // Register read-back
    logic [31:0] rd_nxt;
    logic [31:0] rdata_r;
    always_comb begin
        rd_nxt = '0;
        if (sel_ctrl) begin
            rd_nxt = 32'(ctrl_r);
        end else if (sel_stat) begin
            rd_nxt = {22'h000000, pins_s, clk_s, rca_ok_r, pullup_r,
                wide_r, spi_r};
        end else if (sel_txd) begin
            rd_nxt = 32'(txd_r);
        end else if (sel_rca && !spi_r) begin
            rd_nxt = 32'(rca_r);
        end else if (sel_info && info_ok) begin
            rd_nxt = info_mem[info_idx];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_nxt : '0;
        end
    end

    assign reg_rdata = rdata_r;
    assign pin_oe = pin_oe_r;
    assign pin_out = pin_out_r;
    assign detect_pullup_en = pullup_r;
    assign spi_mode = spi_r;
    assign serial_in = spi_r & pins_s.cmd;
    assign refclk_on_data = ctrl_r.diff_mode;
    assign lane_zero_drive = ctrl_r.diff_mode & ctrl_r.half_duplex;
    assign lane_one_drive = ctrl_r.diff_mode;
    assign local_addr_valid = rca_ok_r & ~spi_r;
    assign local_addr = local_addr_valid ? rca_r : RCA_RST;
    assign driver_stage = dsr_r;

    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    property p_narrow_idle;
        mode == MODE_NATIVE && !wide_r && !ctrl_r.io_mode
            |=> pin_oe.dat[3:1] == 3'b000;
    endproperty
    a_narrow_idle: assert property (p_narrow_idle)
        else $error("upper data lines driven before width select");

    property p_wide_take;
        width_cmd && reg_wdata[CB_WIDE] && !spi_r && !reset_cmd
            ##1 (ctrl_r.xfer_en && mode == MODE_NATIVE)[*2]
            |-> pin_oe.dat[3:1] == 3'b111;
    endproperty
    a_wide_take: assert property (p_wide_take)
        else $error("wide transfer not driving upper data lines");

    property p_pullup_boot;
        $past(rst) |-> detect_pullup_en;
    endproperty
    a_pullup_boot: assert property (p_pullup_boot)
        else $error("pull-up not on after power-up");

    property p_mode_pick;
        reset_cmd |=> spi_mode == $past(cs_low);
    endproperty
    a_mode_pick: assert property (p_mode_pick)
        else $error("mode not taken from detect line");

    property p_pullup_off;
        pullup_cmd && !reg_wdata[CB_CONNECT]
            |=> !detect_pullup_en;
    endproperty
    a_pullup_off: assert property (p_pullup_off)
        else $error("pull-up not removed");

    property p_spi_pins;
        mode == MODE_SPI |=> pin_oe.cmd == 1'b0
            && pin_oe.dat[3:1] == 3'b000 && pin_oe.dat[0] == $past(cs_low);
    endproperty
    a_spi_pins: assert property (p_spi_pins)
        else $error("serial mode pin map wrong");

    property p_irq_line;
        mode == MODE_NATIVE && io_irq && !busy_wide
            |=> pin_oe.dat[1] && !pin_out.dat[1];
    endproperty
    a_irq_line: assert property (p_irq_line)
        else $error("interrupt not shown on data line 1");

    property p_rca_spi;
        reg_rd && sel_rca && spi_r |=> reg_rdata == 32'h00000000;
    endproperty
    a_rca_spi: assert property (p_rca_spi)
        else $error("relative address visible in serial mode");

    property p_rca_approve;
        approve_cmd && !spi_r && !reset_cmd
            |=> local_addr_valid && local_addr == $past(rca_r);
    endproperty
    a_rca_approve: assert property (p_rca_approve)
        else $error("approved address not in use");

    property p_idle_reset;
        reset_cmd |=> !wide_r && !local_addr_valid && rca_r == RCA_RST;
    endproperty
    a_idle_reset: assert property (p_idle_reset)
        else $error("reset command left width or address");

    property p_diff_quiet;
        mode == MODE_DIFF |=> pin_oe.cmd == 1'b0 && pin_oe.dat[3] == 1'b0
            && pin_oe.dat[1:0] == 2'b00 && pin_oe.dat[2] == $past(io_irq);
    endproperty
    a_diff_quiet: assert property (p_diff_quiet)
        else $error("unused line driven in differential mode");

    property p_lanes;
        ctrl_r.diff_mode |-> lane_one_drive
            && lane_zero_drive == ctrl_r.half_duplex;
    endproperty
    a_lanes: assert property (p_lanes)
        else $error("lane direction wrong");

    c_spi: cover property (reset_cmd && cs_low ##1 spi_mode);
    c_wide: cover property (width_cmd ##1 wide_r ##1 pin_oe.dat[3]);
    c_pullup: cover property (pullup_cmd ##1 !detect_pullup_en);
    c_half: cover property (lane_zero_drive && pin_oe.dat[2]);

endmodule

// >>> tb/mcp_host_model.sv
/*
 * Host controller model at the card contacts: card clock, command
 * level, detect line drive and the undriven-line pattern.
 * Assumes the card enables are high while the card drives a contact.
 */
`timescale 1ns/1ns
module mcp_host_model (
    // Pattern clock
    input wire logic clk_sys,
    // Host controls: detect 0 release, 1 high, 2 low
    input wire logic [1:0] det_mode,
    input wire logic cmd_level,
    input wire logic clk_run,
    input wire logic hold_low,
    // Card contacts
    input wire mcp_pkg::mcp_pins_s pin_out,
    input wire mcp_pkg::mcp_pins_s pin_oe,
    input wire logic detect_pullup_en,
    output logic card_clk_pin,
    output mcp_pkg::mcp_pins_s pin_in,
    output logic card_present
);
    import mcp_pkg::*;
    logic float_r = 1'b0;

    // Released lines toggle so a stale level never passes for a value
    always @(posedge clk_sys) begin
        float_r <= ~float_r;
    end

    // Clock stands low outside frames; split halves give 125 ns
    initial card_clk_pin = 1'b0;
    always begin
        if (clk_run && !hold_low) begin
            #62;
            card_clk_pin = 1'b1;
            #63;
            card_clk_pin = 1'b0;
        end else begin
            #7;
        end
    end

    always_comb begin
        // Command held at a level of its own, never floating
        pin_in.cmd = pin_oe.cmd ? pin_out.cmd : (cmd_level && !hold_low);
        for (int i = 0; i < 3; i++) begin
            // Host data lines stay inputs while unused
            if (pin_oe.dat[i]) begin
                pin_in.dat[i] = pin_out.dat[i];
            end else begin
                pin_in.dat[i] = hold_low ? 1'b0 : float_r ^ i[0];
            end
        end
        if (pin_oe.dat[3]) begin
            pin_in.dat[3] = pin_out.dat[3];
        end else if (hold_low) begin
            pin_in.dat[3] = 1'b0;
        end else if (det_mode == 2'd1) begin
            pin_in.dat[3] = 1'b1;
        end else if (det_mode == 2'd2) begin
            pin_in.dat[3] = 1'b0;
        end else begin
            pin_in.dat[3] = detect_pullup_en ? 1'b1 : float_r;
        end
    end

    assign card_present = (det_mode == 2'd0) && pin_in.dat[3];
endmodule

// >>> tb/mcp_pin_mode_tb.sv
/*
 * Self-checking bench for the card pin mode controller.
 * Assumes the host model drives all contacts and the card clock.
 */
`timescale 1ns/1ns
module mcp_pin_mode_tb;
    import mcp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic card_clk_pin;
    mcp_pins_s pin_in;
    mcp_pins_s pin_out;
    mcp_pins_s pin_oe;
    logic detect_pullup_en;
    logic spi_mode;
    logic serial_in;
    logic refclk_on_data;
    logic lane_zero_drive;
    logic lane_one_drive;
    logic [RCA_W-1:0] local_addr;
    logic local_addr_valid;
    logic [DSR_W-1:0] driver_stage;
    logic [1:0] det_mode = 2'd0;
    logic cmd_level = 1'b1;
    logic clk_run = 1'b0;
    logic hold_low = 1'b0;
    logic card_present;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;

    always #5 clk_sys = ~clk_sys;

    mcp_pin_mode #(.INFO_WORDS(28), .HAS_DSR(1'b1)) mcp_pin_mode_i (
        .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .card_clk_pin(card_clk_pin),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .detect_pullup_en(detect_pullup_en), .spi_mode(spi_mode),
        .serial_in(serial_in), .refclk_on_data(refclk_on_data),
        .lane_zero_drive(lane_zero_drive),
        .lane_one_drive(lane_one_drive), .local_addr(local_addr),
        .local_addr_valid(local_addr_valid),
        .driver_stage(driver_stage)
    );

    mcp_host_model mcp_host_model_i (
        .clk_sys(clk_sys), .det_mode(det_mode), .cmd_level(cmd_level),
        .clk_run(clk_run), .hold_low(hold_low), .pin_out(pin_out),
        .pin_oe(pin_oe), .detect_pullup_en(detect_pullup_en),
        .card_clk_pin(card_clk_pin), .pin_in(pin_in),
        .card_present(card_present)
    );

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] mask,
                         input logic [31:0] exp);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata & mask, exp);
    endtask

    // Registered outputs plus two-flop contact sampling
    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask

    // Run needs about 200 cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge clk_sys);
        rst <= 1'b0;
        settle(1);
        check(pin_oe, 32'h0);
        check(detect_pullup_en, 32'h1);
        check(card_present, 32'h1);
        check(local_addr_valid, 32'h0);
        rdchk(A_STAT, 32'hF, 32'h4);
        // Native mode, lines 1-3 held until width select
        wr(A_CMD, 32'h4);
        settle(6);
        check(spi_mode, 32'h0);
        check(serial_in, 32'h0);
        wr(A_CTRL, 32'h8);
        settle(3);
        check(pin_oe.dat[3:1], 32'h0);
        wr(A_CMD, 32'h11);
        settle(3);
        check(pin_oe.dat, 32'hF);
        wr(A_TXD, 32'h1A);
        rdchk(A_TXD, 32'h1F, 32'h1A);
        clk_run <= 1'b1;
        settle(40);
        clk_run <= 1'b0;
        check(pin_out.dat, 32'hA);
        // Interrupt and read wait in I/O mode
        wr(A_CTRL, 32'h11);
        settle(3);
        check({pin_oe.dat[1], pin_out.dat[1]}, 32'h2);
        wr(A_CTRL, 32'h21);
        settle(3);
        check({pin_oe.dat[2], pin_out.dat[2]}, 32'h2);
        wr(A_CTRL, 32'h1);
        settle(3);
        check(pin_oe.dat, 32'h0);
        wr(A_CTRL, 32'h40);
        settle(3);
        check({pin_oe.cmd, pin_out.cmd}, 32'h3);
        rdchk(A_CTRL, 32'h7F, 32'h40);
        // Detect pull-up off and on again
        wr(A_CMD, 32'h2);
        settle(2);
        check(detect_pullup_en, 32'h0);
        rdchk(A_STAT, 32'h4, 32'h0);
        wr(A_CMD, 32'h22);
        settle(2);
        check(detect_pullup_en, 32'h1);
        // Address proposal, approval, then frozen
        wr(A_RCA, 32'hABCD);
        wr(A_CMD, 32'h8);
        settle(2);
        check(local_addr_valid, 32'h1);
        check(local_addr, 32'hABCD);
        wr(A_RCA, 32'h1111);
        rdchk(A_RCA, 32'hFFFF, 32'hABCD);
        wr(A_DSR, 32'hBE);
        settle(2);
        check(driver_stage, 32'hBE);
        rdchk(A_DSR, 32'hFFFFFFFF, 32'h0);
        rdchk(8'hF0, 32'hFFFFFFFF, 32'h0);
        rdchk(8'h18, 32'hFFFFFFFF, 32'h0);
        wr(8'h80, 32'h12345678);
        wr(8'hEC, 32'hCAFEF00D);
        rdchk(8'h80, 32'hFFFFFFFF, 32'h12345678);
        rdchk(8'hEC, 32'hFFFFFFFF, 32'hCAFEF00D);
        // Serial mode picked by a low detect line at reset command
        @(posedge clk_sys) det_mode <= 2'd2;
        wr(A_CTRL, 32'h0);
        settle(4);
        wr(A_CMD, 32'h4);
        settle(6);
        check(spi_mode, 32'h1);
        check(local_addr_valid, 32'h0);
        rdchk(A_RCA, 32'hFFFFFFFF, 32'h0);
        check(pin_oe.dat, 32'h1);
        @(posedge clk_sys) cmd_level <= 1'b1;
        settle(5);
        check(serial_in, 32'h1);
        @(posedge clk_sys) cmd_level <= 1'b0;
        settle(5);
        check(serial_in, 32'h0);
        wr(A_CTRL, 32'h8);
        wr(A_CMD, 32'h11);
        settle(3);
        check(pin_oe.dat[3:1], 32'h0);
        // Differential mode
        @(posedge clk_sys) det_mode <= 2'd1;
        settle(4);
        wr(A_CMD, 32'h4);
        wr(A_CTRL, 32'h2);
        @(posedge clk_sys) hold_low <= 1'b1;
        settle(6);
        check(spi_mode, 32'h0);
        check(refclk_on_data, 32'h1);
        check({lane_zero_drive, lane_one_drive}, 32'h1);
        check({pin_oe.cmd, pin_oe.dat[3:2]}, 32'h0);
        wr(A_CTRL, 32'h6);
        settle(2);
        check({lane_zero_drive, lane_one_drive}, 32'h3);
        wr(A_CTRL, 32'h17);
        settle(3);
        check({pin_oe.dat[3:2], pin_out.dat[2]}, 32'h2);
        check(pin_oe.cmd, 32'h0);
        rdchk(A_STAT, 32'h3FF, 32'h4);
        tally_and_finish();
    end
endmodule
